// [agor_regs.sv]
`timescale 1ns/1ps
`default_nettype none
`include "agor_defines.svh"
// Function
// R1: hold bit freezes streaming address
// R2: reset pulse only on 0-to-1 edge
// R3: host writes 0 then 1
// R4: gain high 6:0 at 0x022, low 0x023
// R5: offset high 6:0 at 0x025, reset 0x40
// R6: offset ignored during background calibration
// R7: mode register resets to 0x00
// R8: ascend increments, descend decrements, wrapping
// R9: offset low at 0x026, 0x4000 neutral
// R10: reserved bits read back, no effect
module agor_regs (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic reqValid,
  input wire agor_pkg::agor_req_t req,
  input wire logic streamNext,
  input wire logic ascendSelect,
  input wire logic bgCalEnable,
  output logic [7:0] rdata,
  output logic [14:0] nextAddr,
  output logic digitalResetPulse,
  output var agor_pkg::agor_trim_t trim
);
  logic [7:0] modeReg_q;
  logic [7:0] porReg_q;
  logic [7:0] gainHi_q;
  logic [7:0] gainLo_q;
  logic [7:0] offHi_q;
  logic [7:0] offLo_q;
  logic trigPrev_q;
  logic [14:0] curAddr_q;
  logic [14:0] stepAddr;
  logic wr;
  logic [7:0] rdata_d;
  logic [`AGOR_REG_COUNT-1:0] hitVec;
  logic [`AGOR_ADDR_W-1:0] ofsTable [`AGOR_REG_COUNT];
  logic wrMode;
  logic wrPor;
  logic wrGainHi;
  logic wrGainLo;
  logic wrOffHi;
  logic wrOffLo;
  logic [14:0] gainField;
  logic [14:0] offsetField;
  logic [14:0] offsetApplied;

  // requests only count while the clock enable is high
  assign wr = clkEn & reqValid & req.write;

  assign ofsTable[`AGOR_IDX_MODE] = `AGOR_OFS_STREAM_MODE;
  assign ofsTable[`AGOR_IDX_POR] = `AGOR_OFS_SOFT_POR;
  assign ofsTable[`AGOR_IDX_GAIN_HI] = `AGOR_OFS_GAIN_HI;
  assign ofsTable[`AGOR_IDX_GAIN_LO] = `AGOR_OFS_GAIN_LO;
  assign ofsTable[`AGOR_IDX_OFFSET_HI] = `AGOR_OFS_OFFSET_HI;
  assign ofsTable[`AGOR_IDX_OFFSET_LO] = `AGOR_OFS_OFFSET_LO;

  // one comparator per mapped register
  genvar gi;
  generate
    for (gi = 0; gi < `AGOR_REG_COUNT; gi++) begin : g_hit
      assign hitVec[gi] = (req.addr == ofsTable[gi]);
    end
  endgenerate

  // unmapped writes match no strobe and are dropped
  assign wrMode = wr & hitVec[`AGOR_IDX_MODE];
  assign wrPor = wr & hitVec[`AGOR_IDX_POR];
  assign wrGainHi = wr & hitVec[`AGOR_IDX_GAIN_HI];
  assign wrGainLo = wr & hitVec[`AGOR_IDX_GAIN_LO];
  assign wrOffHi = wr & hitVec[`AGOR_IDX_OFFSET_HI];
  assign wrOffLo = wr & hitVec[`AGOR_IDX_OFFSET_LO];

  agor_addr_step uStep (
    .addrIn(curAddr_q),
    .holdAddr(modeReg_q[`AGOR_BIT_ADDR_HOLD]),
    .ascend(ascendSelect),
    .addrOut(stepAddr)
  );

  // address tracks request, then steps while streaming
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      curAddr_q <= `AGOR_ADDR_MIN;
    end else if (clkEn && reqValid) begin
      curAddr_q <= req.addr;
    end else if (clkEn && streamNext) begin
      // R1: step or hold
      curAddr_q <= stepAddr;
    end
  end
  assign nextAddr = stepAddr;

  // R7: mode reset 0x00; R10 reserved kept
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      modeReg_q <= `AGOR_RST_STREAM_MODE;
    end else if (wrMode) begin
      modeReg_q <= req.wdata;
    end
  end

  // soft reset register is not cleared by its own pulse
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      porReg_q <= `AGOR_RST_SOFT_POR;
    end else if (wrPor) begin
      porReg_q <= req.wdata;
    end
  end

  // R2: previous trigger level
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      trigPrev_q <= 1'b0;
    end else if (clkEn) begin
      trigPrev_q <= porReg_q[`AGOR_BIT_RESET_TRIG];
    end
  end

  // R2: pulse on rising edge only
  // rewriting 1 finds trigPrev_q high, so no second pulse
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      digitalResetPulse <= 1'b0;
    end else if (clkEn) begin
      digitalResetPulse <= porReg_q[`AGOR_BIT_RESET_TRIG] & ~trigPrev_q;
    end
  end

  // R4: gain high byte
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      gainHi_q <= `AGOR_RST_GAIN_HI;
    end else if (wrGainHi) begin
      gainHi_q <= req.wdata;
    end
  end

  // R4: gain low byte
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      gainLo_q <= `AGOR_RST_GAIN_LO;
    end else if (wrGainLo) begin
      gainLo_q <= req.wdata;
    end
  end

  // R5: offset high byte
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      offHi_q <= `AGOR_RST_OFFSET_HI;
    end else if (wrOffHi) begin
      offHi_q <= req.wdata;
    end
  end

  // R9: offset low byte
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      offLo_q <= `AGOR_RST_OFFSET_LO;
    end else if (wrOffLo) begin
      offLo_q <= req.wdata;
    end
  end

  // R10: bit 7 dropped from trims
  assign gainField = {gainHi_q[`AGOR_TRIM_HI_MSB:0], gainLo_q};
  assign offsetField = {offHi_q[`AGOR_TRIM_HI_MSB:0], offLo_q};

  // R6: neutral offset under background calibration
  assign offsetApplied = bgCalEnable ? `AGOR_OFFSET_NONE : offsetField;

  // bytes apply as written, so a half-written pair shows briefly
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      trim.gain <= `AGOR_RST_GAIN_FIELD;
    end else if (clkEn) begin
      trim.gain <= gainField;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      trim.offset <= `AGOR_OFFSET_NONE;
    end else if (clkEn) begin
      trim.offset <= offsetApplied;
    end
  end

  // unmapped addresses read zero
  always_comb begin
    case (req.addr)
      `AGOR_OFS_STREAM_MODE: rdata_d = modeReg_q;
      `AGOR_OFS_SOFT_POR: rdata_d = porReg_q;
      `AGOR_OFS_GAIN_HI: rdata_d = gainHi_q;
      `AGOR_OFS_GAIN_LO: rdata_d = gainLo_q;
      `AGOR_OFS_OFFSET_HI: rdata_d = offHi_q;
      `AGOR_OFS_OFFSET_LO: rdata_d = offLo_q;
      default: rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else if (clkEn && reqValid && !req.write) begin
      rdata <= rdata_d;
    end
  end
endmodule : agor_regs
`default_nettype wire

// [agor_defines.svh]
`ifndef AGOR_DEFINES_SVH
`define AGOR_DEFINES_SVH
`define AGOR_ADDR_W 15
`define AGOR_OFS_STREAM_MODE 15'h0010
`define AGOR_OFS_SOFT_POR 15'h0021
`define AGOR_OFS_GAIN_HI 15'h0022
`define AGOR_OFS_GAIN_LO 15'h0023
`define AGOR_OFS_OFFSET_HI 15'h0025
`define AGOR_OFS_OFFSET_LO 15'h0026
`define AGOR_RST_STREAM_MODE 8'h00
`define AGOR_RST_SOFT_POR 8'h00
`define AGOR_RST_GAIN_HI 8'h40
`define AGOR_RST_GAIN_LO 8'h00
`define AGOR_RST_OFFSET_HI 8'h40
`define AGOR_RST_OFFSET_LO 8'h00
`define AGOR_BIT_ADDR_HOLD 0
`define AGOR_BIT_RESET_TRIG 0
`define AGOR_TRIM_HI_MSB 6
`define AGOR_ADDR_MAX 15'h7FFF
`define AGOR_ADDR_MIN 15'h0000
`define AGOR_ADDR_STEP 15'h0001
`define AGOR_OFFSET_NONE 15'h4000
`define AGOR_RST_GAIN_FIELD 15'h4000
`define AGOR_REG_COUNT 6
`define AGOR_IDX_MODE 0
`define AGOR_IDX_POR 1
`define AGOR_IDX_GAIN_HI 2
`define AGOR_IDX_GAIN_LO 3
`define AGOR_IDX_OFFSET_HI 4
`define AGOR_IDX_OFFSET_LO 5
`endif

// [agor_pkg.sv]
package agor_pkg;
  typedef struct packed {
    logic [14:0] addr;
    logic write;
    logic [7:0] wdata;
  } agor_req_t;
  typedef struct packed {
    logic [14:0] gain;
    logic [14:0] offset;
  } agor_trim_t;
endpackage : agor_pkg

// [agor_addr_step.sv]
`timescale 1ns/1ps
`default_nettype none
`include "agor_defines.svh"
module agor_addr_step (
  input wire logic [14:0] addrIn,
  input wire logic holdAddr,
  input wire logic ascend,
  output logic [14:0] addrOut
);
  always_comb begin
    // R1: hold or step
    if (holdAddr) begin
      addrOut = addrIn;
    // R8: natural wrap both ways
    end else if (ascend) begin
      addrOut = (addrIn == `AGOR_ADDR_MAX) ? `AGOR_ADDR_MIN : addrIn + `AGOR_ADDR_STEP;
    end else begin
      addrOut = (addrIn == `AGOR_ADDR_MIN) ? `AGOR_ADDR_MAX : addrIn - `AGOR_ADDR_STEP;
    end
  end
endmodule : agor_addr_step
`default_nettype wire

// [agor_regs_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module agor_regs_monitor (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic reqValid,
  input wire agor_pkg::agor_req_t req,
  input wire logic bgCalEnable,
  input wire logic [7:0] rdata,
  input wire logic digitalResetPulse,
  input wire agor_pkg::agor_trim_t trim
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire logic wr = clkEn && reqValid && req.write;
  wire logic rd = clkEn && reqValid && !req.write;
  a_reset_clear: assert property (disable iff (1'b0) !rst_n |=> rdata == 8'h00) else $error("rst");
  a_unmapped_zero: assert property (rd && req.addr == 15'h11 |=> rdata == 8'h00) else $error("unmap");
  a_gain_low: assert property (wr && req.addr == 15'h23 ##1 clkEn [*2]
    |=> trim.gain[7:0] == $past(req.wdata, 3)) else $error("gain");
  a_offset_low: assert property (wr && req.addr == 15'h26 ##1 (clkEn && !bgCalEnable) [*2]
    |=> trim.offset[7:0] == $past(req.wdata, 3)) else $error("offset");
  a_bgcal_neutral: assert property (clkEn && bgCalEnable |=> trim.offset == 15'h4000) else $error("bgcal");
  a_freeze_state: assert property (!clkEn |=> $stable(rdata) && $stable(trim)) else $error("freeze");
  a_pulse_single: assert property (digitalResetPulse && clkEn |=> !digitalResetPulse) else $error("pulse");
  a_pulse_cause: assert property ($rose(digitalResetPulse)
    |-> $past(wr && req.addr == 15'h21 && req.wdata[0], 2)) else $error("cause");
endmodule : agor_regs_monitor
bind agor_regs agor_regs_monitor mon_u (.*);
`default_nettype wire

// [agor_host.sv]
`timescale 1ns/1ps
`default_nettype none
module agor_host (
  input wire logic clk,
  output var logic reqValid,
  output var agor_pkg::agor_req_t req
);
  initial begin
    reqValid = 1'b0;
    req = '0;
  end
  // released bus shows inverted junk, never the last value
  task automatic xfer(input logic w, input logic [14:0] a, input logic [7:0] d);
    req <= '{a, w, d};
    reqValid <= 1'b1;
    @(posedge clk);
    reqValid <= 1'b0;
    req <= '{~a, 1'b0, ~d};
    @(posedge clk);
  endtask : xfer
endmodule : agor_host
`default_nettype wire

// [testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 0, rst_n = 0, clkEn = 1, bgCalEnable = 0, ascendSelect = 0, streamNext = 0;
  logic reqValid, digitalResetPulse, s1, s2;
  logic [7:0] rdata, v[6], expQ[$], rv[6] = '{8'h00, 8'h00, 8'h40, 8'h00, 8'h40, 8'h00};
  logic [14:0] nextAddr, adr[6] = '{15'h10, 15'h21, 15'h22, 15'h23, 15'h25, 15'h26};
  agor_pkg::agor_req_t req;
  agor_pkg::agor_trim_t trim;
  int miscompares, cmp_count, pulses, p;
  agor_regs dut_u (.*);
  agor_host host_u (.*);
  task automatic check(logic [14:0] got, logic [14:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %0t: got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic rd(logic [14:0] a, logic [7:0] e);
    expQ.push_back(e);
    host_u.xfer(1'b0, a, 8'h00);
  endtask : rd
  task automatic stream(logic asc, logic [14:0] a, logic [14:0] e, logic [14:0] e2);
    ascendSelect <= asc;
    rd(a, 8'h00);
    @(negedge clk);
    check(nextAddr, e);
    @(posedge clk);
    streamNext <= 1'b1;
    @(posedge clk);
    streamNext <= 1'b0;
    @(negedge clk);
    check(nextAddr, e2);
    @(posedge clk);
  endtask : stream
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : print_verdict
  always @(posedge clk) begin
    s1 <= clkEn && reqValid && !req.write;
    s2 <= s1;
    pulses <= pulses + digitalResetPulse;
  end
  always @(negedge clk) if (s2 === 1'b1) check({7'h00, rdata}, {7'h00, expQ.pop_front()});
  initial forever #2 clk = ~clk;
  initial begin
    #20000;
    miscompares++;
    print_verdict();
  end
  initial begin
    void'($urandom(32'h19E3BCE5));
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    check(trim.offset, 15'h4000);
    check(trim.gain, 15'h4000);
    @(posedge clk);
    foreach (adr[i]) rd(adr[i], rv[i]);
    rd(15'h11, 8'h00);
    $display("reset done");
    foreach (adr[i]) begin
      v[i] = 8'($urandom);
      host_u.xfer(1'b1, adr[i], v[i]);
      rd(adr[i], v[i]);
    end
    @(negedge clk);
    check(trim.gain, {v[2][6:0], v[3]});
    check(trim.offset, {v[4][6:0], v[5]});
    @(posedge clk);
    bgCalEnable <= 1'b1;
    clkEn <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    check(trim.offset, {v[4][6:0], v[5]});
    @(posedge clk);
    clkEn <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    check(trim.offset, 15'h4000);
    @(posedge clk);
    bgCalEnable <= 1'b0;
    p = pulses;
    host_u.xfer(1'b1, 15'h21, 8'h00);
    host_u.xfer(1'b1, 15'h21, 8'h01);
    host_u.xfer(1'b1, 15'h21, 8'hFF);
    repeat (3) @(posedge clk);
    check(15'(pulses - p), 15'h1);
    $display("trims done");
    host_u.xfer(1'b1, 15'h10, 8'h00);
    stream(1'b1, 15'h7FFF, 15'h0, 15'h1);
    stream(1'b0, 15'h0, 15'h7FFF, 15'h7FFE);
    host_u.xfer(1'b1, 15'h10, 8'h01);
    stream(1'b0, 15'h123, 15'h123, 15'h123);
    $display("stream done");
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
